// ---- verilog/avr_map.svh ----
`ifndef AVR_MAP_SVH
`define AVR_MAP_SVH

// register addresses
`define AVR_ADDR_SOFT_MUTE    8'h06
`define AVR_ADDR_MASTER       8'h07
`define AVR_ADDR_CH1          8'h08
`define AVR_ADDR_CH2          8'h09
`define AVR_ADDR_LIMITER_VOL  8'h0A
`define AVR_ADDR_RAMP_CFG     8'h0E
`define AVR_ADDR_MOD_CAP      8'h10
`define AVR_ADDR_SKEW_CH1     8'h11
`define AVR_ADDR_SKEW_CH2     8'h12
`define AVR_ADDR_SKEW_CH1_INV 8'h13
`define AVR_ADDR_SKEW_CH2_INV 8'h14
`define AVR_ADDR_STOP_GROUP   8'h19

// reset values
`define AVR_RST_SOFT_MUTE   8'h00
`define AVR_RST_MASTER      16'h03FF
`define AVR_RST_CHANNEL     16'h00C0
`define AVR_RST_LIMITER_VOL 16'h0000
`define AVR_RST_RAMP_CFG    8'h60
`define AVR_RST_MOD_CAP     8'h01
`define AVR_RST_SKEW_A      8'hAC
`define AVR_RST_SKEW_B      8'h54
`define AVR_RST_STOP_GROUP  8'h00

// writable bit masks, reserved bits read zero
`define AVR_MASK_SOFT_MUTE  8'h07
`define AVR_MASK_VOLUME     16'h03FF
`define AVR_MASK_RAMP_CFG   8'h67
`define AVR_MASK_MOD_CAP    8'h07
`define AVR_MASK_SKEW       8'hFC
`define AVR_MASK_STOP_GROUP 8'h0F

// field positions
`define AVR_BIT_CH4_SRC   6
`define AVR_BIT_CH3_SRC   5
`define AVR_SLEW_MSB      2
`define AVR_SKEW_MSB      7
`define AVR_SKEW_LSB      2

// gain codes
`define AVR_VOL_MUTE      10'h3FF
`define AVR_VOL_ZERO_DB   10'h0C0
`define AVR_VOL_MAX_CODE  11'h3FF

// ramp step periods in ns and the clock period
`define AVR_STEP_NS_8K    125000
`define AVR_STEP_NS_11K   90700
`define AVR_STEP_NS_12K   83300
`define AVR_CLK_NS        8

`endif

// ---- verilog/avr_pkg.sv ----
package avr_pkg;

    // sample-rate family that sets the ramp step period
    typedef enum logic [1:0]
    {
        AVR_RATE_8K,
        AVR_RATE_11K,
        AVR_RATE_12K
    } avr_rate_type;

    typedef enum logic [0:0]
    {
        AVR_IDLE,
        AVR_RAMP
    } avr_ramp_state_type;

    typedef struct packed
    {
        logic [7:0]  soft_mute;
        logic [15:0] master;
        logic [15:0] ch1;
        logic [15:0] ch2;
        logic [15:0] limiter_vol;
        logic [7:0]  ramp_cfg;
        logic [7:0]  mod_cap;
        logic [7:0]  skew1;
        logic [7:0]  skew2;
        logic [7:0]  skew1_inv;
        logic [7:0]  skew2_inv;
        logic [7:0]  stop_group;
        logic [15:0] rd_data;
        logic [16:0] tick_cnt;
        logic [9:0]  cur_gain1;
        logic [9:0]  cur_gain2;
        logic [11:0] steps_left;
        avr_ramp_state_type state;
        logic [3:0]  running;
        logic        shut_prev;
    } avr_state_type;

endpackage : avr_pkg

// ---- verilog/avr_regs.sv ----
// How it works
// - soft-mute bit forces 50% duty output
// - mute bits D0..D2 for channels 1..3
// - volume registers two bytes, 0.125 dB steps
// - code 0 is +24 dB, 0x3FF mutes
// - master volume resets to mute code
// - channel volumes reset to 0 dB
// - ramp step period follows sample-rate family
// - slew field picks 512/1024/2048/256 steps
// - slew applies to volume and mute ramps; with SOFT_UNMUTE_SEL low, only to shutdown ramps
// - D6 picks channel-4 limiter volume source
// - D5 picks channel-3 limiter volume source
// - modulation cap field, default 98.4%
// - four skew registers at 0x11..0x14
// - signed six-bit skew times four clocks
// - skew registers reset to AD values
// - group channels stay stopped when GROUP_HOLD_OFF low
// - stop-group bits D0..D3, default zero
// - 0x07/0x08/0x09 are master, ch1, ch2
// - shutdown bit set holds all outputs off
// - soft unmute uses the slew ramp length
`timescale 1ns/1ns
`default_nettype none
`include "avr_map.svh"

module avr_regs
    import avr_pkg::*;
#(
    parameter int STEP_NS_8K  = `AVR_STEP_NS_8K,
    parameter int STEP_NS_11K = `AVR_STEP_NS_11K,
    parameter int STEP_NS_12K = `AVR_STEP_NS_12K
)
(
    input  wire logic          CLOCK,
    input  wire logic          RST,
    input  wire logic          WR_EN,
    input  wire logic          RD_EN,
    input  wire logic [7:0]    ADDR,
    input  wire logic [15:0]   WR_DATA,
    output logic      [15:0]   RD_DATA,
    input  wire avr_rate_type  RATE_FAMILY,
    input  wire logic          SHUTDOWN,
    input  wire logic          GROUP_HOLD_OFF,
    input  wire logic          SOFT_UNMUTE_SEL,
    output logic      [9:0]    GAIN_CH1,
    output logic      [9:0]    GAIN_CH2,
    output logic      [9:0]    LIMITER_GAIN_CH3,
    output logic      [9:0]    LIMITER_GAIN_CH4,
    output logic      [2:0]    MUTE_HALF_DUTY,
    output logic      [2:0]    MOD_CAP_CODE,
    output logic      [3:0]    CHANNEL_RUN,
    output logic      [11:0]   SLEW_STEPS,
    output logic      [7:0]    SKEW_CH1,
    output logic      [7:0]    SKEW_CH2,
    output logic      [7:0]    SKEW_CH1_INV,
    output logic      [7:0]    SKEW_CH2_INV,
    output logic               RAMP_BUSY
);

    // step periods in clock cycles, rounded down so steps never run late
    localparam int STEP_CYC_8K  = STEP_NS_8K / `AVR_CLK_NS;
    localparam int STEP_CYC_11K = STEP_NS_11K / `AVR_CLK_NS;
    localparam int STEP_CYC_12K = STEP_NS_12K / `AVR_CLK_NS;

    avr_state_type cur_ff;
    avr_state_type nxt_ff;

    logic [16:0] step_period;
    logic        step_tick;
    logic [10:0] sum1;
    logic [10:0] sum2;
    logic [9:0]  target1;
    logic [9:0]  target2;
    logic [11:0] slew_len;
    logic        target_moved;

    // step period chosen by the incoming sample-rate family
    always_comb
    begin
        unique case (RATE_FAMILY)
            AVR_RATE_8K:  step_period = 17'(STEP_CYC_8K);
            AVR_RATE_11K: step_period = 17'(STEP_CYC_11K);
            AVR_RATE_12K: step_period = 17'(STEP_CYC_12K);
            default:      step_period = 17'(STEP_CYC_12K);
        endcase
    end

    assign step_tick = (cur_ff.tick_cnt == 17'h0_0000);

    // slew length; reserved 1xx codes fall back to the default length
    always_comb
    begin
        unique case (cur_ff.ramp_cfg[`AVR_SLEW_MSB:0])
            3'h1:    slew_len = 12'h400;
            3'h2:    slew_len = 12'h800;
            3'h3:    slew_len = 12'h100;
            default: slew_len = 12'h200;
        endcase
    end

    // gain codes add in dB; saturate so any mute code stays mute
    assign sum1 = {1'b0, cur_ff.master[9:0]} + {1'b0, cur_ff.ch1[9:0]}
                  - {1'b0, `AVR_VOL_ZERO_DB};
    assign sum2 = {1'b0, cur_ff.master[9:0]} + {1'b0, cur_ff.ch2[9:0]}
                  - {1'b0, `AVR_VOL_ZERO_DB};

    // shutdown or a mute code in master or channel targets the mute code; a sum below
    // 0 dB offset wraps in 11 bits, so it is clamped before the overflow test
    always_comb
    begin
        if (SHUTDOWN || cur_ff.master[9:0] == `AVR_VOL_MUTE
            || cur_ff.ch1[9:0] == `AVR_VOL_MUTE)
            target1 = `AVR_VOL_MUTE;
        else if ({1'b0, cur_ff.master[9:0]} + {1'b0, cur_ff.ch1[9:0]}
                 < {1'b0, `AVR_VOL_ZERO_DB})
            target1 = 10'h000;
        else if (sum1 >= `AVR_VOL_MAX_CODE)
            target1 = `AVR_VOL_MUTE;
        else
            target1 = sum1[9:0];
        if (SHUTDOWN || cur_ff.master[9:0] == `AVR_VOL_MUTE
            || cur_ff.ch2[9:0] == `AVR_VOL_MUTE)
            target2 = `AVR_VOL_MUTE;
        else if ({1'b0, cur_ff.master[9:0]} + {1'b0, cur_ff.ch2[9:0]}
                 < {1'b0, `AVR_VOL_ZERO_DB})
            target2 = 10'h000;
        else if (sum2 >= `AVR_VOL_MAX_CODE)
            target2 = `AVR_VOL_MUTE;
        else
            target2 = sum2[9:0];
    end

    assign target_moved = (target1 != cur_ff.cur_gain1) || (target2 != cur_ff.cur_gain2);

    // next-state logic: register writes, reads, ramp and run control
    always_comb
    begin
        nxt_ff = cur_ff;

        // register writes, reserved bits masked off
        if (WR_EN)
        begin
            unique case (ADDR)
                `AVR_ADDR_SOFT_MUTE:
                    nxt_ff.soft_mute = WR_DATA[7:0] & `AVR_MASK_SOFT_MUTE;
                `AVR_ADDR_MASTER:
                    nxt_ff.master = WR_DATA & `AVR_MASK_VOLUME;
                `AVR_ADDR_CH1:
                    nxt_ff.ch1 = WR_DATA & `AVR_MASK_VOLUME;
                `AVR_ADDR_CH2:
                    nxt_ff.ch2 = WR_DATA & `AVR_MASK_VOLUME;
                `AVR_ADDR_LIMITER_VOL:
                    nxt_ff.limiter_vol = WR_DATA & `AVR_MASK_VOLUME;
                `AVR_ADDR_RAMP_CFG:
                    nxt_ff.ramp_cfg = WR_DATA[7:0] & `AVR_MASK_RAMP_CFG;
                `AVR_ADDR_MOD_CAP:
                    nxt_ff.mod_cap = WR_DATA[7:0] & `AVR_MASK_MOD_CAP;
                `AVR_ADDR_SKEW_CH1:
                    nxt_ff.skew1 = WR_DATA[7:0] & `AVR_MASK_SKEW;
                `AVR_ADDR_SKEW_CH2:
                    nxt_ff.skew2 = WR_DATA[7:0] & `AVR_MASK_SKEW;
                `AVR_ADDR_SKEW_CH1_INV:
                    nxt_ff.skew1_inv = WR_DATA[7:0] & `AVR_MASK_SKEW;
                `AVR_ADDR_SKEW_CH2_INV:
                    nxt_ff.skew2_inv = WR_DATA[7:0] & `AVR_MASK_SKEW;
                `AVR_ADDR_STOP_GROUP:
                    nxt_ff.stop_group = WR_DATA[7:0] & `AVR_MASK_STOP_GROUP;
                default:
                    nxt_ff.stop_group = cur_ff.stop_group;
            endcase
        end

        // read data registered; unmapped addresses read zero
        if (RD_EN)
        begin
            unique case (ADDR)
                `AVR_ADDR_SOFT_MUTE:    nxt_ff.rd_data = {8'h00, cur_ff.soft_mute};
                `AVR_ADDR_MASTER:       nxt_ff.rd_data = cur_ff.master;
                `AVR_ADDR_CH1:          nxt_ff.rd_data = cur_ff.ch1;
                `AVR_ADDR_CH2:          nxt_ff.rd_data = cur_ff.ch2;
                `AVR_ADDR_LIMITER_VOL:  nxt_ff.rd_data = cur_ff.limiter_vol;
                `AVR_ADDR_RAMP_CFG:     nxt_ff.rd_data = {8'h00, cur_ff.ramp_cfg};
                `AVR_ADDR_MOD_CAP:      nxt_ff.rd_data = {8'h00, cur_ff.mod_cap};
                `AVR_ADDR_SKEW_CH1:     nxt_ff.rd_data = {8'h00, cur_ff.skew1};
                `AVR_ADDR_SKEW_CH2:     nxt_ff.rd_data = {8'h00, cur_ff.skew2};
                `AVR_ADDR_SKEW_CH1_INV: nxt_ff.rd_data = {8'h00, cur_ff.skew1_inv};
                `AVR_ADDR_SKEW_CH2_INV: nxt_ff.rd_data = {8'h00, cur_ff.skew2_inv};
                `AVR_ADDR_STOP_GROUP:   nxt_ff.rd_data = {8'h00, cur_ff.stop_group};
                default:                nxt_ff.rd_data = 16'h0000;
            endcase
        end

        // step timer free-runs so a ramp starts on the next step boundary
        if (step_tick)
            nxt_ff.tick_cnt = step_period - 17'h0_0001;
        else
            nxt_ff.tick_cnt = cur_ff.tick_cnt - 17'h0_0001;

        // ramp: one code per step, budget of slew_len steps per change, the step that spends the budget jumps to the target;
        // hard unmute (select low) after shutdown jumps in a single step
        unique case (cur_ff.state)
            AVR_IDLE:
            begin
                if (target_moved)
                begin
                    nxt_ff.state      = AVR_RAMP;
                    nxt_ff.steps_left = slew_len;
                end
            end
            AVR_RAMP:
            begin
                if (!SOFT_UNMUTE_SEL && !SHUTDOWN)
                begin
                    nxt_ff.cur_gain1 = target1;
                    nxt_ff.cur_gain2 = target2;
                    nxt_ff.state     = AVR_IDLE;
                end
                else if (step_tick)
                begin
                    if (cur_ff.cur_gain1 < target1)
                        nxt_ff.cur_gain1 = cur_ff.cur_gain1 + 10'h001;
                    else if (cur_ff.cur_gain1 > target1)
                        nxt_ff.cur_gain1 = cur_ff.cur_gain1 - 10'h001;
                    if (cur_ff.cur_gain2 < target2)
                        nxt_ff.cur_gain2 = cur_ff.cur_gain2 + 10'h001;
                    else if (cur_ff.cur_gain2 > target2)
                        nxt_ff.cur_gain2 = cur_ff.cur_gain2 - 10'h001;
                    nxt_ff.steps_left = cur_ff.steps_left - 12'h001;
                    // ramp ends when target reached or the step budget is spent
                    if (!target_moved || cur_ff.steps_left == 12'h001)
                    begin
                        nxt_ff.state = AVR_IDLE;
                        if (cur_ff.steps_left == 12'h001)
                        begin
                            nxt_ff.cur_gain1 = target1;
                            nxt_ff.cur_gain2 = target2;
                        end
                    end
                end
            end
        endcase

        // run control: start all on shutdown release, group channels
        // stay stopped unless the hold-off bit is set
        nxt_ff.shut_prev = SHUTDOWN;
        if (SHUTDOWN)
            nxt_ff.running = 4'h0;
        else if (cur_ff.shut_prev)
            nxt_ff.running = GROUP_HOLD_OFF ? 4'hF : ~cur_ff.stop_group[3:0];
    end

    // single state register
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            cur_ff             <= '0;
            cur_ff.soft_mute   <= `AVR_RST_SOFT_MUTE;
            cur_ff.master      <= `AVR_RST_MASTER;
            cur_ff.ch1         <= `AVR_RST_CHANNEL;
            cur_ff.ch2         <= `AVR_RST_CHANNEL;
            cur_ff.limiter_vol <= `AVR_RST_LIMITER_VOL;
            cur_ff.ramp_cfg    <= `AVR_RST_RAMP_CFG;
            cur_ff.mod_cap     <= `AVR_RST_MOD_CAP;
            cur_ff.skew1       <= `AVR_RST_SKEW_A;
            cur_ff.skew2       <= `AVR_RST_SKEW_B;
            cur_ff.skew1_inv   <= `AVR_RST_SKEW_A;
            cur_ff.skew2_inv   <= `AVR_RST_SKEW_B;
            cur_ff.stop_group  <= `AVR_RST_STOP_GROUP;
            cur_ff.cur_gain1   <= `AVR_VOL_MUTE;
            cur_ff.cur_gain2   <= `AVR_VOL_MUTE;
            cur_ff.state       <= AVR_IDLE;
            cur_ff.shut_prev   <= 1'b1;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // outputs straight from state
    assign RD_DATA        = cur_ff.rd_data;
    assign GAIN_CH1       = cur_ff.cur_gain1;
    assign GAIN_CH2       = cur_ff.cur_gain2;
    assign MUTE_HALF_DUTY = cur_ff.soft_mute[2:0];
    assign MOD_CAP_CODE   = cur_ff.mod_cap[2:0];
    assign CHANNEL_RUN    = cur_ff.running;
    assign SLEW_STEPS     = slew_len;
    assign RAMP_BUSY      = (cur_ff.state == AVR_RAMP);
    // skew fields passed in place: signed value in D7..D2, times four clocks
    assign SKEW_CH1       = cur_ff.skew1;
    assign SKEW_CH2       = cur_ff.skew2;
    assign SKEW_CH1_INV   = cur_ff.skew1_inv;
    assign SKEW_CH2_INV   = cur_ff.skew2_inv;

    // limiter volume sources per configuration bits
    assign LIMITER_GAIN_CH4 = cur_ff.ramp_cfg[`AVR_BIT_CH4_SRC]
                              ? cur_ff.limiter_vol[9:0] : cur_ff.ch1[9:0];
    assign LIMITER_GAIN_CH3 = cur_ff.ramp_cfg[`AVR_BIT_CH3_SRC]
                              ? cur_ff.limiter_vol[9:0] : cur_ff.ch2[9:0];

endmodule : avr_regs
`default_nettype wire

// ---- bench/avr_regs_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the register block
module avr_regs_props
    import avr_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        WR_EN,
    input wire logic        RD_EN,
    input wire logic [7:0]  ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic [15:0] RD_DATA,
    input wire logic        SHUTDOWN,
    input wire logic        GROUP_HOLD_OFF,
    input wire logic [9:0]  GAIN_CH1,
    input wire logic [2:0]  MUTE_HALF_DUTY,
    input wire logic [2:0]  MOD_CAP_CODE,
    input wire logic [3:0]  CHANNEL_RUN,
    input wire logic [11:0] SLEW_STEPS,
    input wire logic [7:0]  SKEW_CH1,
    input wire logic        RAMP_BUSY
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    // reserved slew codes fall back to the default length
    function automatic logic [11:0] slew_of(input logic [2:0] c);
        return (c == 3'd1) ? 12'h400 : (c == 3'd2) ? 12'h800 : (c == 3'd3) ? 12'h100 : 12'h200;
    endfunction : slew_of

    mute_bit_map_a: assert property (
        WR_EN && ADDR == 8'h06 |=> MUTE_HALF_DUTY == $past(WR_DATA[2:0]))
        else $error("soft mute bits do not follow the write");
    cap_code_a: assert property (
        WR_EN && ADDR == 8'h10 |=> MOD_CAP_CODE == $past(WR_DATA[2:0]))
        else $error("modulation cap code does not follow the write");
    skew_store_a: assert property (
        WR_EN && ADDR == 8'h11 |=> SKEW_CH1 == ($past(WR_DATA[7:0]) & 8'hFC))
        else $error("skew value or reserved bits wrong");
    slew_len_a: assert property (
        WR_EN && ADDR == 8'h0E |=> SLEW_STEPS == slew_of($past(WR_DATA[2:0])))
        else $error("ramp length does not match slew code");
    group_readback_a: assert property (
        WR_EN && ADDR == 8'h19 ##2 RD_EN && ADDR == 8'h19
        |=> RD_DATA == {12'h000, $past(WR_DATA[3:0], 3)})
        else $error("stop group read back wrong");
    shut_hold_a: assert property (
        SHUTDOWN ##1 SHUTDOWN |=> CHANNEL_RUN == 4'h0)
        else $error("channel runs during shutdown");
    group_free_a: assert property (
        $fell(SHUTDOWN) && GROUP_HOLD_OFF ##1 !SHUTDOWN && GROUP_HOLD_OFF |=> CHANNEL_RUN == 4'hF)
        else $error("channels not all started with group hold off");
    gain_step_a: assert property (
        RAMP_BUSY && $past(RAMP_BUSY) && !SHUTDOWN && !$past(SHUTDOWN)
        |-> 10'(GAIN_CH1 - $past(GAIN_CH1) + 10'd1) <= 10'd2)
        else $error("gain moved more than one code in a ramp");

    cover property ($fell(RAMP_BUSY));
    cover property ($fell(SHUTDOWN) && !GROUP_HOLD_OFF);
    cover property (RD_EN && ADDR == 8'h1F);
endmodule : avr_regs_props

bind avr_regs avr_regs_props u_props (.CLOCK(CLOCK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN),
    .ADDR(ADDR), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .SHUTDOWN(SHUTDOWN),
    .GROUP_HOLD_OFF(GROUP_HOLD_OFF), .GAIN_CH1(GAIN_CH1), .MUTE_HALF_DUTY(MUTE_HALF_DUTY),
    .MOD_CAP_CODE(MOD_CAP_CODE), .CHANNEL_RUN(CHANNEL_RUN), .SLEW_STEPS(SLEW_STEPS),
    .SKEW_CH1(SKEW_CH1), .RAMP_BUSY(RAMP_BUSY));
`default_nettype wire

// ---- bench/avr_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// host controller side of the register port
module avr_host
(
    input  wire logic        CLOCK,
    output logic             WR_EN = 1'b0,
    output logic             RD_EN = 1'b0,
    output logic [7:0]       ADDR = 8'h00,
    output logic [15:0]      WR_DATA = 16'h0000,
    input  wire logic [15:0] RD_DATA
);
    // a released bus shows the inverse, so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WR_DATA <= d;
        @(posedge CLOCK);
        WR_EN <= 1'b0;
        ADDR <= ~a;
        WR_DATA <= ~d;
    endtask : wr

    // read data is taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLOCK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge CLOCK);
        RD_EN <= 1'b0;
        ADDR <= ~a;
        @(posedge CLOCK);
        d = RD_DATA;
    endtask : rd

    // skew values for three-level modulation, loaded while still shut down
    task automatic bd_load();
        wr(8'h11, 16'h00B8);
        wr(8'h12, 16'h0060);
        wr(8'h13, 16'h00A0);
        wr(8'h14, 16'h0048);
    endtask : bd_load

    // two-band limiter setup: both limiter gains from the extra register
    task automatic two_band(input logic [7:0] cfg);
        wr(8'h0A, 16'h0030);
        wr(8'h0E, {8'h00, cfg | 8'h60});
    endtask : two_band
endmodule : avr_host
`default_nettype wire

// ---- bench/avr_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module avr_regs_tb import avr_pkg::*;;
    localparam int STEP[3] = '{10, 8, 6}; // cycles per step with the shortened periods
    localparam logic [7:0] MAP[13] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0E, 8'h10,
        8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h1F};
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic SHUTDOWN = 1'b1;
    logic GROUP_HOLD_OFF = 1'b0;
    logic SOFT_UNMUTE_SEL = 1'b1;
    avr_rate_type RATE_FAMILY = AVR_RATE_8K;
    logic WR_EN, RD_EN, RAMP_BUSY;
    logic [7:0] ADDR, a, SKEW_CH1, SKEW_CH2, SKEW_CH1_INV, SKEW_CH2_INV;
    logic [15:0] WR_DATA, RD_DATA, rdv;
    logic [9:0] GAIN_CH1, GAIN_CH2, LIMITER_GAIN_CH3, LIMITER_GAIN_CH4;
    logic [2:0] MUTE_HALF_DUTY, MOD_CAP_CODE;
    logic [3:0] CHANNEL_RUN;
    logic [11:0] SLEW_STEPS;
    logic [15:0] mdl[32];
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    int seed = 32'h8779_94ae;

    avr_regs #(.STEP_NS_8K(80), .STEP_NS_11K(64), .STEP_NS_12K(48)) uut (.CLOCK(CLOCK),
        .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .RD_DATA(RD_DATA), .RATE_FAMILY(RATE_FAMILY), .SHUTDOWN(SHUTDOWN),
        .GROUP_HOLD_OFF(GROUP_HOLD_OFF), .SOFT_UNMUTE_SEL(SOFT_UNMUTE_SEL), .GAIN_CH1(GAIN_CH1),
        .GAIN_CH2(GAIN_CH2), .LIMITER_GAIN_CH3(LIMITER_GAIN_CH3),
        .LIMITER_GAIN_CH4(LIMITER_GAIN_CH4), .MUTE_HALF_DUTY(MUTE_HALF_DUTY),
        .MOD_CAP_CODE(MOD_CAP_CODE), .CHANNEL_RUN(CHANNEL_RUN), .SLEW_STEPS(SLEW_STEPS),
        .SKEW_CH1(SKEW_CH1), .SKEW_CH2(SKEW_CH2), .SKEW_CH1_INV(SKEW_CH1_INV),
        .SKEW_CH2_INV(SKEW_CH2_INV), .RAMP_BUSY(RAMP_BUSY));
    avr_host host (.CLOCK(CLOCK), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
        .WR_DATA(WR_DATA), .RD_DATA(RD_DATA));

    always #4 CLOCK = ~CLOCK;

    // writable bits per address; unmapped places keep nothing
    function automatic logic [15:0] msk(input logic [7:0] ad);
        case (ad)
            8'h06, 8'h10: return 16'h0007;
            8'h07, 8'h08, 8'h09, 8'h0A: return 16'h03FF;
            8'h0E: return 16'h0067;
            8'h11, 8'h12, 8'h13, 8'h14: return 16'h00FC;
            8'h19: return 16'h000F;
            default: return 16'h0000;
        endcase
    endfunction : msk

    // model snoops the strobe, so writes made inside the host are tracked too
    always @(posedge CLOCK)
        if (!RST && WR_EN === 1'b1 && ADDR < 8'h20)
            mdl[ADDR[4:0]] <= WR_DATA & msk(ADDR);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] ad);
        host.rd(ad, rdv);
        chk(rdv, mdl[ad[4:0]]);
    endtask : rdchk

    task automatic outs();
        @(negedge CLOCK);
        chk({13'h0, MUTE_HALF_DUTY}, mdl[6]);
        chk({13'h0, MOD_CAP_CODE}, mdl[16]);
        chk({SKEW_CH1, SKEW_CH2}, {mdl[17][7:0], mdl[18][7:0]});
        chk({SKEW_CH1_INV, SKEW_CH2_INV}, {mdl[19][7:0], mdl[20][7:0]});
        chk({4'h0, SLEW_STEPS}, mdl[14][2:0] == 3'd1 ? 16'h0400 : mdl[14][2:0] == 3'd2 ?
            16'h0800 : mdl[14][2:0] == 3'd3 ? 16'h0100 : 16'h0200);
        chk({6'h0, LIMITER_GAIN_CH4}, mdl[14][6] ? mdl[10] : mdl[8]);
        chk({6'h0, LIMITER_GAIN_CH3}, mdl[14][5] ? mdl[10] : mdl[9]);
    endtask : outs

    task automatic run_is(input logic [3:0] exp);
        repeat (4) @(posedge CLOCK);
        @(negedge CLOCK);
        chk({12'h0, CHANNEL_RUN}, {12'h0, exp});
        @(posedge CLOCK);
    endtask : run_is

    // the first two negedges cover the edge that starts the ramp
    task automatic wait_idle(output int k);
        k = 0;
        do
        begin
            @(negedge CLOCK);
            k++;
        end
        while ((k < 3 || RAMP_BUSY !== 1'b0) && k < 30000);
    endtask : wait_idle

    // first change is ignored, its phase is unknown; second gap is one full step
    task automatic step_gap(output int k);
        logic [9:0] g;
        repeat (2)
        begin
            g = GAIN_CH1;
            k = 0;
            do
            begin
                @(negedge CLOCK);
                k++;
            end
            while (GAIN_CH1 === g && k < 100);
        end
    endtask : step_gap

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ceiling well above the longest ramp sequence
    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    initial
    begin
        foreach (mdl[i]) mdl[i] = 16'h0000;
        mdl[7] = 16'h03FF;
        mdl[8] = 16'h00C0;
        mdl[9] = 16'h00C0;
        mdl[14] = 16'h0060;
        mdl[16] = 16'h0001;
        mdl[17] = 16'h00AC;
        mdl[18] = 16'h0054;
        mdl[19] = 16'h00AC;
        mdl[20] = 16'h0054;
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        foreach (MAP[i]) rdchk(MAP[i]);
        outs();
        chk({12'h0, CHANNEL_RUN}, 16'h0000);
        repeat (40)
        begin
            a = MAP[$unsigned($random(seed)) % 13];
            host.wr(a, 16'($random(seed)));
            rdchk(a);
        end
        outs();
        host.bd_load();
        host.two_band(8'h03);
        foreach (MAP[i]) rdchk(MAP[i]);
        outs();
        host.wr(8'h19, 16'h00F5);
        SHUTDOWN <= 1'b0;
        run_is(4'hA);
        SHUTDOWN <= 1'b1;
        run_is(4'h0);
        GROUP_HOLD_OFF <= 1'b1;
        SHUTDOWN <= 1'b0;
        run_is(4'hF);
        host.wr(8'h08, 16'h00C0);
        host.wr(8'h09, 16'h00C0);
        host.wr(8'h0E, 16'h0003);
        host.wr(8'h07, 16'h0100);
        wait_idle(n);
        for (int r = 0; r < 3; r++)
        begin
            @(posedge CLOCK);
            RATE_FAMILY <= avr_rate_type'(r);
            host.wr(8'h07, r[0] ? 16'h0100 : 16'h0120);
            step_gap(n);
            chk(16'(n), 16'(STEP[r]));
            wait_idle(n);
            chk({6'h0, GAIN_CH1}, mdl[7]);
            chk({6'h0, GAIN_CH2}, mdl[7]);
        end
        host.wr(8'h08, 16'h00D0);
        wait_idle(n);
        chk({GAIN_CH1, GAIN_CH2}, {10'h130, 10'h120});
        host.wr(8'h07, 16'h03FF);
        wait_idle(n);
        chk(16'(n >= 1530 && n <= 1550), 16'h0001);
        chk({6'h0, GAIN_CH1}, 16'h03FF);
        outs();
        // hard unmute select: gain jumps to 0x100 + 0xD0 - 0xC0 in one step
        @(posedge CLOCK);
        SOFT_UNMUTE_SEL <= 1'b0;
        host.wr(8'h07, 16'h0100);
        repeat (3) @(posedge CLOCK);
        @(negedge CLOCK);
        chk({6'h0, GAIN_CH1}, 16'h0110);
        give_verdict();
    end
endmodule : avr_regs_tb
`default_nettype wire
